/* src/three_stage_cpu_pipeline.v */
// fetch/decode/execute pipeline control with scratchpad and multiplier
`include "cpu_pipe_map.vh"

module half_word_multiplier_unit #(
  parameter W = 16
) (
  input  wire           clk_sys_i,
  input  wire           ce_i,
  input  wire [W-1:0]   a_i,
  input  wire [W-1:0]   b_i,
  output reg  [2*W-1:0] p_o
);
  always @(posedge clk_sys_i) begin
    if (ce_i) begin
      p_o <= a_i * b_i;
    end
  end
endmodule // half_word_multiplier_unit

module three_stage_cpu_pipeline #(
  parameter [31:0] BOOT_ADDR = `BOOT_ADDR_DEF,
  parameter [31:0] IRQ_ADDR  = `IRQ_ADDR_DEF,
  parameter        RF_DEPTH  = `RF_DEPTH_DEF,
  parameter        RF_AW     = `RF_AW_DEF,
  parameter        MUL_W     = `MUL_W_DEF
) (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        ce_i,
  input  wire        irq_i,
  input  wire        fetch_busy_i,
  input  wire [31:0] fetch_data_i,
  output reg         fetch_req_o,
  output reg  [29:0] fetch_addr_o,
  output reg         irq_ack_o,
  output reg         wb_valid_o,
  output reg  [7:0]  wb_addr_o,
  output reg  [31:0] wb_data_o
);
  localparam DW = `RF_DW_DEF;

  // fetch stage
  reg        pending;
  reg        drop;
  reg        hold_valid;
  reg [31:0] hold;
  // decode stage
  reg        dec_valid;
  reg [31:0] dec_inst;
  reg [1:0]  col_hit;
  reg [DW-1:0] col_val;
  // execute stage
  reg        ex_valid;
  reg [3:0]  ex_op;
  reg [7:0]  ex_dst;
  reg [31:0] ex_a;
  reg [31:0] ex_b;
  reg        mul_phase;

  wire [2*MUL_W-1:0] mul_p;
  wire [2*DW-1:0]    ram_q;
  wire [2*RF_AW-1:0] ram_addr;

  function is_write;
    input [3:0] op;
    begin
      is_write = (op == `OP_ADD) || (op == `OP_SUB) || (op == `OP_AND) ||
                 (op == `OP_OR) || (op == `OP_XOR) || (op == `OP_MUL);
    end
  endfunction

  // operand select: immediate, live forward, edge collision, then RAM
  function [31:0] pick_operand;
    input        imm;
    input        used;
    input [7:0]  field;
    input        fwd_hit;
    input [31:0] fwd_val;
    input        c_hit;
    input [31:0] c_val;
    input [31:0] q;
    begin
      if (!used) begin
        pick_operand = 32'h00000000;
      end else if (imm) begin
        pick_operand = {{24{field[7]}}, field};
      end else if (fwd_hit) begin
        pick_operand = fwd_val;
      end else if (c_hit) begin
        pick_operand = c_val;
      end else begin
        pick_operand = q;
      end
    end
  endfunction

  wire accept     = fetch_req_o && !fetch_busy_i;
  wire arrive     = pending && !fetch_busy_i;
  wire word_ok    = arrive && !drop;
  wire [31:0] word       = hold_valid ? hold : fetch_data_i;
  wire        word_valid = hold_valid || word_ok;

  wire stall   = ex_valid && (ex_op == `OP_MUL) && !mul_phase;
  wire ex_done = ex_valid && !stall;
  wire jump    = ex_done && (ex_op == `OP_JMP);
  // irq level is used as it arrives, no local sync flops
  wire irq_take = ex_done && !jump && irq_i;
  wire flush    = jump || irq_take;
  wire [29:0] target = jump ? ex_a[31:`WORD_LSB] : IRQ_ADDR[31:`WORD_LSB];

  wire [3:0] dec_op    = dec_inst[`OPC_HI:`OPC_LO];
  wire       next_stall = dec_valid && (dec_op == `OP_MUL) && !stall && !flush;

  // execute result and write port
  reg [31:0] ex_res;
  always @* begin
    case (ex_op)
      `OP_ADD: ex_res = ex_a + ex_b;
      `OP_SUB: ex_res = ex_a - ex_b;
      `OP_AND: ex_res = ex_a & ex_b;
      `OP_OR:  ex_res = ex_a | ex_b;
      `OP_XOR: ex_res = ex_a ^ ex_b;
      `OP_MUL: ex_res = mul_p[31:0];
      default: ex_res = 32'h00000000;
    endcase
  end
  wire       rf_we    = ex_done && is_write(ex_op);
  wire [7:0] rf_waddr = ex_dst;

  // read addresses come from the raw word; a stall re-reads decode's own
  assign ram_addr = stall ? dec_inst[`SRC1_HI:`SRC2_LO]
                          : word[`SRC1_HI:`SRC2_LO];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : rd_port
      register_ram_unit #(
        .AW    (RF_AW),
        .DW    (DW),
        .DEPTH (RF_DEPTH)
      ) u_ram (
        .clk_sys_i (clk_sys_i),
        .ce_i      (ce_i),
        .we_i      (rf_we),
        .waddr_i   (rf_waddr),
        .wdata_i   (ex_res),
        .raddr_i   (ram_addr[gi*RF_AW +: RF_AW]),
        .rdata_o   (ram_q[gi*DW +: DW])
      );
    end
  endgenerate

  half_word_multiplier_unit #(
    .W (MUL_W)
  ) u_mul (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .a_i       (ex_a[MUL_W-1:0]),
    .b_i       (ex_b[MUL_W-1:0]),
    .p_o       (mul_p)
  );

  // decode operand formation; port 1 is src1, port 0 is src2
  wire [7:0] d_src1 = dec_inst[`SRC1_HI:`SRC1_LO];
  wire [7:0] d_src2 = dec_inst[`SRC2_HI:`SRC2_LO];
  wire use_a = (dec_op != `OP_NOP);
  wire use_b = use_a && (dec_op != `OP_JMP);
  wire [31:0] dec_a = pick_operand(dec_inst[`IMM1_BIT], use_a, d_src1,
                                   rf_we && (rf_waddr == d_src1), ex_res,
                                   col_hit[1], col_val, ram_q[2*DW-1:DW]);
  wire [31:0] dec_b = pick_operand(dec_inst[`IMM2_BIT], use_b, d_src2,
                                   rf_we && (rf_waddr == d_src2), ex_res,
                                   col_hit[0], col_val, ram_q[DW-1:0]);

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      fetch_req_o  <= 1'b1;
      fetch_addr_o <= BOOT_ADDR[31:`WORD_LSB];
      pending      <= 1'b0;
      drop         <= 1'b0;
      hold_valid   <= 1'b0;
      hold         <= 32'h00000000;
      dec_valid    <= 1'b0;
      dec_inst     <= 32'h00000000;
      col_hit      <= 2'h0;
      col_val      <= 32'h00000000;
      ex_valid     <= 1'b0;
      ex_op        <= `OP_NOP;
      ex_dst       <= 8'h00;
      ex_a         <= 32'h00000000;
      ex_b         <= 32'h00000000;
      mul_phase    <= 1'b0;
      irq_ack_o    <= 1'b0;
      wb_valid_o   <= 1'b0;
      wb_addr_o    <= 8'h00;
      wb_data_o    <= 32'h00000000;
    end else if (ce_i) begin
      // fetch: at most one request outstanding
      pending <= accept ? 1'b1 : (arrive ? 1'b0 : pending);
      if (flush) begin
        drop         <= accept || (pending && !arrive);
        fetch_addr_o <= target;
        hold_valid   <= 1'b0;
        fetch_req_o  <= 1'b1;
      end else begin
        if (arrive && drop) begin
          drop <= 1'b0;
        end
        if (accept) begin
          fetch_addr_o <= fetch_addr_o + `PC_STEP;
        end
        if (stall && word_ok) begin
          hold_valid <= 1'b1;
          hold       <= fetch_data_i;
        end else if (!stall) begin
          hold_valid <= 1'b0;
        end
        fetch_req_o <= !next_stall;
      end
      // edge collision capture for the RAM read just issued
      col_hit <= {rf_we && (rf_waddr == ram_addr[2*RF_AW-1:RF_AW]),
                  rf_we && (rf_waddr == ram_addr[RF_AW-1:0])};
      col_val <= ex_res;
      // decode
      if (flush) begin
        dec_valid <= 1'b0;
      end else if (!stall) begin
        dec_valid <= word_valid;
        dec_inst  <= word;
      end
      // execute
      if (stall) begin
        mul_phase <= 1'b1;
      end else begin
        mul_phase <= 1'b0;
        ex_valid  <= dec_valid && !flush;
        ex_op     <= dec_op;
        ex_dst    <= dec_inst[`DST_HI:`DST_LO];
        ex_a      <= dec_a;
        ex_b      <= dec_b;
      end
      irq_ack_o  <= irq_take;
      wb_valid_o <= rf_we;
      wb_addr_o  <= rf_waddr;
      wb_data_o  <= ex_res;
    end
  end
endmodule // three_stage_cpu_pipeline

/* src/cpu_pipe_map.vh */
// constants and instruction field layout for the three-stage pipeline
`ifndef CPU_PIPE_MAP_VH
`define CPU_PIPE_MAP_VH

`define OPC_HI        31
`define OPC_LO        28
`define IMM1_BIT      27
`define IMM2_BIT      26
`define DST_HI        23
`define DST_LO        16
`define SRC1_HI       15
`define SRC1_LO       8
`define SRC2_HI       7
`define SRC2_LO       0

`define OP_NOP        4'h0
`define OP_ADD        4'h1
`define OP_SUB        4'h2
`define OP_AND        4'h3
`define OP_OR         4'h4
`define OP_XOR        4'h5
`define OP_MUL        4'h6
`define OP_JMP        4'h7

`define BOOT_ADDR_DEF 32'h00000000
`define IRQ_ADDR_DEF  32'h00000100
`define RF_DEPTH_DEF  256
`define RF_AW_DEF     8
`define RF_DW_DEF     32
`define MUL_W_DEF     16
`define PC_STEP       30'h00000001
`define WORD_LSB      2

`endif

/* src/register_ram_unit.v */
// synchronous one-write one-read RAM with registered read data
module register_ram_unit #(
  parameter AW    = 8,
  parameter DW    = 32,
  parameter DEPTH = 256
) (
  input  wire          clk_sys_i,
  input  wire          ce_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // collision behaviour here is deliberately left to the core
  always @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // register_ram_unit

/* verification/pipe_checker_assertions.sv */
// port assertions for the three-stage pipeline
module pipe_checker #(
  parameter [31:0] BOOT_ADDR = 32'h00000000,
  parameter [31:0] IRQ_ADDR  = 32'h00000100
) (
  input logic        clk_sys_i,
  input logic        reset_n_i,
  input logic        ce_i,
  input logic        irq_i,
  input logic        fetch_busy_i,
  input logic [31:0] fetch_data_i,
  input logic        fetch_req_o,
  input logic [29:0] fetch_addr_o,
  input logic        irq_ack_o,
  input logic        wb_valid_o,
  input logic [7:0]  wb_addr_o,
  input logic [31:0] wb_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  property p_boot;
    disable iff (1'b0) !reset_n_i |=> fetch_req_o && fetch_addr_o == BOOT_ADDR[31:2];
  endproperty
  a_boot: assert property (p_boot) else $error("boot");
  property p_quiet;
    disable iff (1'b0) !reset_n_i |=> !wb_valid_o && !irq_ack_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset");
  property p_ack_addr;
    irq_ack_o |-> fetch_req_o && fetch_addr_o == IRQ_ADDR[31:2];
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("irq target");
  property p_ack_cause;
    $rose(irq_ack_o) |-> $past(irq_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("irq cause");
  property p_freeze;
    reset_n_i && !ce_i |=> $stable(fetch_addr_o) && $stable({fetch_req_o, wb_valid_o});
  endproperty
  a_freeze: assert property (p_freeze) else $error("ce");
  property p_first_wb;
    $rose(reset_n_i) |-> !wb_valid_o [*4];
  endproperty
  a_first_wb: assert property (p_first_wb) else $error("depth");
  property p_ack_gap;
    irq_ack_o && ce_i |=> !irq_ack_o [*2];
  endproperty
  a_ack_gap: assert property (p_ack_gap) else $error("ack gap");
  property p_ack_flush;
    irq_ack_o && ce_i |=> !wb_valid_o [*3];
  endproperty
  a_ack_flush: assert property (p_ack_flush) else $error("flush");
  c_wb: cover property (wb_valid_o);
  c_ack: cover property (irq_ack_o);
  c_busy: cover property (fetch_busy_i && fetch_req_o);
endmodule // pipe_checker

bind three_stage_cpu_pipeline pipe_checker #(.BOOT_ADDR(BOOT_ADDR), .IRQ_ADDR(IRQ_ADDR)) u_chk (
  .clk_sys_i, .reset_n_i, .ce_i, .irq_i, .fetch_busy_i, .fetch_data_i,
  .fetch_req_o, .fetch_addr_o, .irq_ack_o, .wb_valid_o, .wb_addr_o, .wb_data_o);

/* verification/prog_mem_model.sv */
// program memory model with optional busy stalls
module prog_mem_model (
  input  logic        clk_sys_i,
  input  logic        ce_i,
  input  logic        stall_i,
  input  logic        fetch_req_i,
  input  logic [29:0] fetch_addr_i,
  output logic        fetch_busy_o,
  output logic [31:0] fetch_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:127];
  logic [31:0] last = 32'h0;
  logic [6:0]  adr  = 7'h0;
  logic        pend = 1'b0;
  logic        busy = 1'b0;
  assign fetch_busy_o = busy;
  // no valid word shown: drive inverse of the last one
  assign fetch_data_o = (pend && !busy) ? mem[adr] : ~last;
  always @(posedge clk_sys_i) begin
    busy <= stall_i;
    if (pend && !busy) last <= mem[adr];
    if (ce_i && !busy) begin
      pend <= fetch_req_i;
      adr  <= fetch_addr_i[6:0];
    end
  end
endmodule // prog_mem_model

/* verification/three_stage_cpu_pipeline_bench.sv */
// testbench for the three-stage pipeline
module three_stage_cpu_pipeline_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        ce_i      = 1'b1;
  logic        irq_i     = 1'b0;
  logic        stall     = 1'b0;
  logic [1:0]  mode      = 2'h0;
  logic [3:0]  cnt       = 4'h0;
  logic        ce_prev   = 1'b1;
  wire         fetch_busy_i;
  wire         fetch_req_o;
  wire         irq_ack_o;
  wire         wb_valid_o;
  wire  [31:0] fetch_data_i;
  wire  [31:0] wb_data_o;
  wire  [29:0] fetch_addr_o;
  wire  [7:0]  wb_addr_o;
  integer      n_mismatch  = 0;
  integer      comparisons = 0;
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // mode 1 opens ce gaps, mode 2 stalls the memory
  always @(posedge clk_sys_i) begin
    cnt   <= cnt + 4'h1;
    ce_prev <= ce_i;
    ce_i  <= mode != 2'h1 || cnt[1:0] != 2'h0;
    stall <= mode == 2'h2 && cnt[0];
  end
  three_stage_cpu_pipeline #(.BOOT_ADDR(32'h00000013)) dut (
    .clk_sys_i, .reset_n_i, .ce_i, .irq_i, .fetch_busy_i, .fetch_data_i,
    .fetch_req_o, .fetch_addr_o, .irq_ack_o, .wb_valid_o, .wb_addr_o, .wb_data_o);
  prog_mem_model pm (.clk_sys_i, .ce_i, .stall_i(stall), .fetch_req_i(fetch_req_o),
    .fetch_addr_i(fetch_addr_o), .fetch_busy_o(fetch_busy_i), .fetch_data_o(fetch_data_i));
  task check(input [31:0] s, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("mismatches %0d of %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task do_reset;
    begin
      reset_n_i <= 1'b0;
      repeat (16) @(posedge clk_sys_i);
      check({2'h0, fetch_addr_o}, 32'h00000004);
      check({31'h0, fetch_req_o}, 32'h1);
      reset_n_i <= 1'b1;
    end
  endtask
  task wait_wb(input [7:0] a, input [31:0] d);
    integer i;
    begin
      i = 0;
      @(posedge clk_sys_i);
      // a pulse frozen through a ce gap is the same write seen again
      while (!(wb_valid_o === 1'b1 && ce_prev === 1'b1) && i < 60) begin
        @(posedge clk_sys_i);
        i = i + 1;
      end
      if (i == 60) begin
        n_mismatch = n_mismatch + 1;
        close_out;
      end else begin
        check({24'h0, wb_addr_o}, {24'h0, a});
        check(wb_data_o, d);
      end
    end
  endtask
  task run_program(input [1:0] m);
    begin
      mode <= m;
      do_reset;
      wait_wb(8'h00, 32'h0000000a);
      wait_wb(8'h01, 32'h00000014);
      wait_wb(8'h02, 32'h0000001e);
      wait_wb(8'h03, 32'h00000258);
      wait_wb(8'h04, 32'h00000259);
    end
  endtask
  task run_irq;
    begin
      mode <= 2'h2;
      irq_i <= 1'b1;
      do_reset;
      wait_wb(8'h00, 32'h0000000a);
      check({31'h0, irq_ack_o}, 32'h1);
      irq_i <= 1'b0;
      wait_wb(8'h05, 32'h00000007);
    end
  endtask
  initial begin
    for (int k = 0; k < 128; k++) pm.mem[k] = 32'h0;
    pm.mem[4]  = 32'h1c000a00;
    pm.mem[5]  = 32'h1c011400;
    pm.mem[6]  = 32'h10020001;
    pm.mem[7]  = 32'h60030201;
    pm.mem[8]  = 32'h78004000;
    pm.mem[9]  = 32'h1c090101;
    pm.mem[16] = 32'h14040301;
    pm.mem[64] = 32'h1c050700;
    run_program(2'h0);
    run_program(2'h1);
    run_irq;
    close_out;
  end
endmodule // three_stage_cpu_pipeline_bench
